// [src/icc_pkg.sv]
// Shared constants and carriers of the input capture channel.
// Assumes one 100 MHz clock and a plain single-cycle register port.
package icc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus shape and register offsets.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_INPUT_SELECT = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_BUFFER       = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE   = 4'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of capture_input_select_5_6.
  localparam int unsigned SEL5_LSB = 0;
  localparam int unsigned SEL6_LSB = 8;
  localparam int unsigned SEL_W    = 7;

  // Field positions of capture_control_one.
  localparam int unsigned CTL_STOP_IDLE = 13;
  localparam int unsigned CTL_TB_LSB    = 10;
  localparam int unsigned CTL_PER_LSB   = 5;
  localparam int unsigned CTL_OVF       = 4;
  localparam int unsigned CTL_BNE       = 3;
  localparam int unsigned CTL_MODE_LSB  = 0;

  // Interrupt status bits.
  localparam int unsigned IRQ_CAPTURE  = 0;
  localparam int unsigned IRQ_OVERFLOW = 1;
  localparam int unsigned IRQ_W        = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Capture modes.
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_EVERY    = 3'h1;
  localparam logic [2:0] MODE_FALL     = 3'h2;
  localparam logic [2:0] MODE_RISE     = 3'h3;
  localparam logic [2:0] MODE_RISE4    = 3'h4;
  localparam logic [2:0] MODE_RISE16   = 3'h5;
  localparam logic [2:0] MODE_UNUSED   = 3'h6;
  localparam logic [2:0] MODE_WAKE     = 3'h7;

  // Timebase select codes.
  localparam logic [2:0] TB_TIMER2     = 3'h1;
  localparam logic [2:0] TB_TIMER4     = 3'h2;
  localparam logic [2:0] TB_TIMER5     = 3'h3;
  localparam logic [2:0] TB_TIMER1     = 3'h4;
  localparam logic [2:0] TB_RESERVED   = 3'h6;
  localparam logic [2:0] TB_PERIPHERAL = 3'h7;

  // Input select codes.
  localparam logic [6:0] PIN_GROUND     = 7'h00;
  localparam logic [6:0] PIN_COMPARATOR = 7'h01;
  localparam logic [6:0] PIN_LAST       = 7'h7C;

  // Prescaler terminal counts.
  localparam logic [3:0] PRE4_LAST  = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;

  // Reset values.
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wr;
    logic              rd;
  } icc_req_s;

  typedef struct packed {
    logic [15:0] timer1Count;
    logic [15:0] timer2Count;
    logic [15:0] timer4Count;
    logic [15:0] timer5Count;
  } icc_timebase_s;

endpackage : icc_pkg

// [src/icc_sync_edge.sv]
// Two-flop synchroniser for the selected input plus edge detection.
// Assumes the input is asynchronous to clk.
module icc_sync_edge (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinAsync,
  output logic      rise,
  output logic      fall
);
  import icc_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } icc_edge_s;

  icc_edge_s state;
  icc_edge_s next_state;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state      = state;
    next_state.meta = pinAsync;
    next_state.sync = state.meta;
    next_state.last = state.sync;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise = state.sync & ~state.last;
  assign fall = ~state.sync & state.last;

endmodule : icc_sync_edge

// [src/icc_capture_fifo.sv]
// Capture buffer: a small first-in first-out store of timebase words.
// Assumes push is never given while full and pop never while empty.
module icc_capture_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] popData,
  output logic                  empty,
  output logic                  full
);
  import icc_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [PW:0]                 count;
  } icc_fifo_s;

  icc_fifo_s state;
  icc_fifo_s next_state;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    if (flush) begin
      next_state.wrPtr = '0;
      next_state.rdPtr = '0;
      next_state.count = '0;
    end else begin
      if (push) begin
        next_state.mem[state.wrPtr] = pushData;
        next_state.wrPtr = state.wrPtr + 1'b1;
      end
      if (pop) begin
        next_state.rdPtr = state.rdPtr + 1'b1;
      end
      next_state.count = state.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign popData = state.mem[state.rdPtr];
  assign empty   = (state.count == '0);
  assign full    = (state.count == (PW+1)'(DEPTH));

endmodule : icc_capture_fifo

// [src/icc_input_capture.sv]
// Input capture channel with pin select, capture buffer and interrupts.
// Assumes timer counts and cpu idle/sleep levels come from logic on clk.
//
// Function
// - Stop-in-idle set halts the channel during processor idle; clear keeps it running.
// - Timebase select picks timer 2, 4, 5, 1 or peripheral clock; 110 reserved.
// - Captures-per-interrupt 11 interrupts every fourth capture, 10 every third.
// - Captures-per-interrupt is ignored in edge-detect mode and wake-pin mode.
// - Overflow flag sets when a capture meets a full buffer; hardware only.
// - Buffer-not-empty reads 1 while a captured value remains, else 0.
// - Mode 000 turns the channel off.
// - Mode 001 captures on every rising and falling edge.
// - Mode 101 captures every sixteenth rising edge, mode 100 every fourth.
// - A 7-bit select ties the input to ground, comparator 1 or remap pins.
//
// The register addresses and the strobed register port are this design's own decisions.
module icc_input_capture #(
  parameter int unsigned DEPTH        = 4,
  parameter bit          USE_CHANNEL6 = 1'b0,
  parameter int unsigned PIN_COUNT    = 125
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire icc_pkg::icc_req_s             regReq,
  output logic [icc_pkg::DATA_W-1:0]         regRdData,
  input  wire logic [PIN_COUNT-1:0]          remapInputs,
  input  wire logic                          comparator1Output,
  input  wire icc_pkg::icc_timebase_s        timebase,
  input  wire logic                          cpuIdle,
  input  wire logic                          cpuSleep,
  output logic                               irq
);
  import icc_pkg::*;

  if (PIN_COUNT < 125 || PIN_COUNT > 128) begin : g_chk
    $error("PIN_COUNT must cover codes up to 124");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [SEL_W-1:0]  sel5;
    logic [SEL_W-1:0]  sel6;
    logic              stopIdle;
    logic [2:0]        tbSel;
    logic [1:0]        perInt;
    logic [2:0]        mode;
    logic              overflow;
    logic [3:0]        preCount;
    logic [1:0]        intCount;
    logic [15:0]       periphCount;
    logic [IRQ_W-1:0]  irqStatus;
    logic [IRQ_W-1:0]  irqEnable;
    logic [DATA_W-1:0] rdData;
  } icc_state_s;

  icc_state_s state;
  icc_state_s next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Maps a select code onto the channel input level.
  function automatic logic pickInput(
    input logic [SEL_W-1:0]     code,
    input logic [PIN_COUNT-1:0] pins,
    input logic                 cmp
  );
    logic lvl;
    lvl = 1'b0;
    if (code == PIN_GROUND) begin
      lvl = 1'b0;
    end else if (code == PIN_COMPARATOR) begin
      lvl = cmp;
    end else if (code <= PIN_LAST) begin
      lvl = pins[code];
    end
    return lvl;
  endfunction : pickInput

  // Returns the timebase word selected for capture.
  function automatic logic [15:0] pickTimebase(
    input logic [2:0]    sel,
    input icc_timebase_s tb,
    input logic [15:0]   periph
  );
    logic [15:0] val;
    val = 16'h0000;
    unique case (sel)
      TB_TIMER2:     val = tb.timer2Count;
      TB_TIMER4:     val = tb.timer4Count;
      TB_TIMER5:     val = tb.timer5Count;
      TB_TIMER1:     val = tb.timer1Count;
      TB_PERIPHERAL: val = periph;
      default:       val = 16'h0000;
    endcase
    return val;
  endfunction : pickTimebase

  // True when a register access hits the given offset.
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Input path.

  logic pinLevel;
  logic pinRise;
  logic pinFall;

  assign pinLevel = pickInput(USE_CHANNEL6 ? state.sel6 : state.sel5,
                              remapInputs, comparator1Output);

  icc_sync_edge u_edge (
    .clk      (clk),
    .rst      (rst),
    .pinAsync (pinLevel),
    .rise     (pinRise),
    .fall     (pinFall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Capture buffer.

  logic        fifoPush;
  logic        fifoPop;
  logic        fifoFlush;
  logic [15:0] fifoHead;
  logic        fifoEmpty;
  logic        fifoFull;
  logic [15:0] captureWord;

  assign captureWord = pickTimebase(state.tbSel, timebase, state.periphCount);

  icc_capture_fifo #(
    .WIDTH (16),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .flush    (fifoFlush),
    .push     (fifoPush),
    .pushData (captureWord),
    .pop      (fifoPop),
    .popData  (fifoHead),
    .empty    (fifoEmpty),
    .full     (fifoFull)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification.

  logic halted;
  logic running;
  logic captureEvt;
  logic wakeEvt;
  logic intEvt;
  logic countedInt;

  // The wake-pin mode stays live in sleep and idle; other modes obey stop-in-idle.
  assign halted  = state.stopIdle && cpuIdle;
  assign running = (state.mode != MODE_OFF) && (state.mode != MODE_UNUSED)
                   && !halted;

  always_comb begin
    captureEvt = 1'b0;
    unique case (state.mode)
      MODE_EVERY:  captureEvt = pinRise | pinFall;
      MODE_FALL:   captureEvt = pinFall;
      MODE_RISE:   captureEvt = pinRise;
      MODE_RISE4:  captureEvt = pinRise && state.preCount == PRE4_LAST;
      MODE_RISE16: captureEvt = pinRise && state.preCount == PRE16_LAST;
      default:     captureEvt = 1'b0;
    endcase
    captureEvt = captureEvt && running;
  end

  assign wakeEvt    = (state.mode == MODE_WAKE) && pinRise && (cpuSleep || cpuIdle);
  assign countedInt = captureEvt && (state.intCount == state.perInt);

  always_comb begin
    if (state.mode == MODE_EVERY) begin
      intEvt = captureEvt;
    end else if (state.mode == MODE_WAKE) begin
      intEvt = wakeEvt;
    end else begin
      intEvt = countedInt;
    end
  end

  assign fifoPush  = captureEvt && !fifoFull;
  assign fifoPop   = regReq.rd && hit(regReq.addr, OFS_BUFFER) && !fifoEmpty;
  assign fifoFlush = (state.mode == MODE_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_state = state;
    next_state.periphCount = state.periphCount + 16'h0001;

    // Prescaler counts rising edges only in the prescaled modes.
    if (running && pinRise &&
        (state.mode == MODE_RISE4 || state.mode == MODE_RISE16)) begin
      if (state.mode == MODE_RISE4 && state.preCount == PRE4_LAST) begin
        next_state.preCount = 4'h0;
      end else begin
        next_state.preCount = state.preCount + 4'h1;
      end
    end

    // Capture counter between interrupts.
    if (captureEvt && state.mode != MODE_EVERY) begin
      if (countedInt) begin
        next_state.intCount = 2'h0;
      end else begin
        next_state.intCount = state.intCount + 2'h1;
      end
    end

    // Overflow clears on the first buffer pop that has no same-cycle capture.
    if (fifoPop && !fifoPush && state.overflow) begin
      next_state.overflow = 1'b0;
    end
    if (captureEvt && fifoFull) begin
      next_state.overflow = 1'b1;
    end

    // Register writes.
    if (regReq.wr) begin
      if (hit(regReq.addr, OFS_INPUT_SELECT)) begin
        next_state.sel5 = regReq.wrData[SEL5_LSB +: SEL_W];
        next_state.sel6 = regReq.wrData[SEL6_LSB +: SEL_W];
      end
      if (hit(regReq.addr, OFS_CONTROL_ONE)) begin
        next_state.stopIdle = regReq.wrData[CTL_STOP_IDLE];
        next_state.tbSel    = regReq.wrData[CTL_TB_LSB +: 3];
        next_state.perInt   = regReq.wrData[CTL_PER_LSB +: 2];
        next_state.mode     = regReq.wrData[CTL_MODE_LSB +: 3];
        if (regReq.wrData[CTL_MODE_LSB +: 3] != state.mode) begin
          next_state.preCount = 4'h0;
          next_state.intCount = 2'h0;
        end
      end
      if (hit(regReq.addr, OFS_IRQ_ENABLE)) begin
        next_state.irqEnable = regReq.wrData[IRQ_W-1:0];
      end
    end

    // Switching off resets the buffer state.
    if (state.mode == MODE_OFF) begin
      next_state.overflow = 1'b0;
      next_state.preCount = 4'h0;
      next_state.intCount = 2'h0;
    end

    // Sticky status: clear first so a same-cycle event still sets.
    if (regReq.wr && hit(regReq.addr, OFS_IRQ_CLEAR)) begin
      next_state.irqStatus = state.irqStatus & ~regReq.wrData[IRQ_W-1:0];
    end
    if (intEvt) begin
      next_state.irqStatus[IRQ_CAPTURE] = 1'b1;
    end
    if (captureEvt && fifoFull) begin
      next_state.irqStatus[IRQ_OVERFLOW] = 1'b1;
    end

    // Read data stands for the single cycle after the strobe.
    next_state.rdData = RST_WORD;
    if (regReq.rd) begin
      unique case (regReq.addr)
        OFS_INPUT_SELECT: begin
          next_state.rdData[SEL5_LSB +: SEL_W] = state.sel5;
          next_state.rdData[SEL6_LSB +: SEL_W] = state.sel6;
        end
        OFS_CONTROL_ONE: begin
          next_state.rdData[CTL_STOP_IDLE]     = state.stopIdle;
          next_state.rdData[CTL_TB_LSB +: 3]   = state.tbSel;
          next_state.rdData[CTL_PER_LSB +: 2]  = state.perInt;
          next_state.rdData[CTL_OVF]           = state.overflow;
          next_state.rdData[CTL_BNE]           = !fifoEmpty;
          next_state.rdData[CTL_MODE_LSB +: 3] = state.mode;
        end
        OFS_BUFFER: begin
          next_state.rdData = fifoEmpty ? RST_WORD : fifoHead;
        end
        OFS_IRQ_STATUS: begin
          next_state.rdData[IRQ_W-1:0] = state.irqStatus;
        end
        OFS_IRQ_ENABLE: begin
          next_state.rdData[IRQ_W-1:0] = state.irqEnable;
        end
        default: begin
          next_state.rdData = RST_WORD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign regRdData = state.rdData;
  assign irq       = |(state.irqStatus & state.irqEnable);

endmodule : icc_input_capture

// [tb/icc_properties.sv]
// Checker of the input capture channel, bound to its top module.
// Assumes only the top ports are seen; shadows keep what software wrote.
module icc_properties #(
  parameter int unsigned DEPTH        = 4,
  parameter bit          USE_CHANNEL6 = 1'b0,
  parameter int unsigned PIN_COUNT    = 125
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire icc_pkg::icc_req_s          regReq,
  input wire logic [icc_pkg::DATA_W-1:0] regRdData,
  input wire logic [PIN_COUNT-1:0]       remapInputs,
  input wire logic                       comparator1Output,
  input wire icc_pkg::icc_timebase_s     timebase,
  input wire logic                       cpuIdle,
  input wire logic                       cpuSleep,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import icc_pkg::*;
  logic [15:0] ctl;
  logic [15:0] sel;
  logic [1:0]  en;
  logic        noCap;
  logic        rdCtl;
  logic        rdSel;
  logic        rdBuf;
  assign rdCtl = regReq.rd && regReq.addr == OFS_CONTROL_ONE;
  assign rdSel = regReq.rd && regReq.addr == OFS_INPUT_SELECT;
  assign rdBuf = regReq.rd && regReq.addr == OFS_BUFFER;
  // After mode off nothing can be stored until a capture mode is written.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl   <= 16'h0000;
      sel   <= 16'h0000;
      en    <= 2'b00;
      noCap <= 1'b1;
    end else if (regReq.wr) begin
      if (regReq.addr == OFS_CONTROL_ONE) ctl <= regReq.wrData;
      if (regReq.addr == OFS_INPUT_SELECT) sel <= regReq.wrData;
      if (regReq.addr == OFS_IRQ_ENABLE) en <= regReq.wrData[1:0];
      if (regReq.addr == OFS_CONTROL_ONE && regReq.wrData[2:0] < MODE_UNUSED)
        noCap <= (regReq.wrData[2:0] == MODE_OFF);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_quiet: assert property (!$past(regReq.rd) |-> regRdData == 16'h0000)
    else $error("read data seen outside a read answer");
  a_ctl_readback: assert property (rdCtl |=> (regRdData & 16'hFFE7) == (ctl & 16'h3C67))
    else $error("control readback differs from written fields");
  a_sel_readback: assert property (rdSel |=> regRdData == (sel & 16'h7F7F))
    else $error("input select readback differs");
  a_off_no_data: assert property (rdBuf && noCap && $past(noCap) |=> regRdData == 16'h0000)
    else $error("buffer holds data in a mode without capture");
  a_off_flags_clear: assert property (rdCtl && noCap && $past(noCap) |=> regRdData[4:3] == 2'b00)
    else $error("buffer flags set in a mode without capture");
  a_overflow_means_full: assert property ($past(rdCtl) && regRdData[4] |-> regRdData[3])
    else $error("overflow shown with an empty buffer");
  a_irq_masked: assert property (en == 2'b00 |-> !irq)
    else $error("interrupt high with all enables clear");
  a_irq_from_status: assert property (regReq.rd && regReq.addr == OFS_IRQ_STATUS && irq
    |=> (regRdData[1:0] & en) != 2'b00)
    else $error("interrupt high without an enabled status bit");
  a_unmapped_zero: assert property (regReq.rd && (regReq.addr > OFS_IRQ_ENABLE
    || regReq.addr == OFS_IRQ_CLEAR) |=> regRdData == 16'h0000)
    else $error("unmapped or clear address read nonzero");
endmodule : icc_properties

bind icc_input_capture icc_properties #(
  .DEPTH(DEPTH), .USE_CHANNEL6(USE_CHANNEL6), .PIN_COUNT(PIN_COUNT)
) icc_properties_i (
  .clk(clk), .rst(rst), .regReq(regReq), .regRdData(regRdData), .remapInputs(remapInputs),
  .comparator1Output(comparator1Output), .timebase(timebase), .cpuIdle(cpuIdle),
  .cpuSleep(cpuSleep), .irq(irq)
);

// [tb/icc_pin_model.sv]
// External signal source feeding the capture channel's input pins.
// Assumes the bench steers one pin level; the other pins carry noise.
module icc_pin_model #(
  parameter int unsigned PIN_COUNT = 125
) (
  input  wire logic                 clk,
  input  wire logic [6:0]           pinSel,
  input  wire logic                 level,
  input  wire logic                 slow,
  output logic      [PIN_COUNT-1:0] remapInputs,
  output logic                      comparator1Output
);
  timeunit 1ns;
  timeprecision 100ps;
  logic noise = 1'b0;
  logic late  = 1'b0;
  always @(posedge clk) begin
    noise <= ~noise;
    late  <= level;
  end
  // Unselected pins toggle every cycle, so a wrong select fills the buffer.
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      remapInputs[i] = (i == int'(pinSel)) ? (slow ? late : level) : noise;
    end
    comparator1Output = (pinSel == 7'h01) ? (slow ? late : level) : noise;
  end
endmodule : icc_pin_model

// [tb/tb.sv]
// Self-checking bench of the input capture channel.
// Assumes the pin model steers the selected pin; the bench drives timers and cpu levels.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import icc_pkg::*;
  logic          clk    = 1'b0;
  logic          rst    = 1'b1;
  icc_req_s      req    = '0;
  logic [15:0]   rdData;
  logic [124:0]  pins;
  logic          cmpOut;
  icc_timebase_s tbase;
  logic          idle   = 1'b0;
  logic          sleep  = 1'b0;
  logic          irq;
  logic [6:0]    pinSel = 7'h00;
  logic          level  = 1'b0;
  logic          slow   = 1'b0;
  logic [15:0]   stamp  = 16'h0001;
  logic [15:0]   v;
  int            err_total = 0;
  int            compares  = 0;
  int            cycles    = 0;
  int            n;
  // Each timer shows a distinct word, so a wrong timebase pick is visible.
  assign tbase = {stamp ^ 16'h1000, stamp, stamp ^ 16'h2000, stamp ^ 16'h3000};
  icc_pin_model icc_pin_model_i (.clk(clk), .pinSel(pinSel), .level(level), .slow(slow),
    .remapInputs(pins), .comparator1Output(cmpOut));
  icc_input_capture icc_input_capture_i (.clk(clk), .rst(rst), .regReq(req), .regRdData(rdData),
    .remapInputs(pins), .comparator1Output(cmpOut), .timebase(tbase), .cpuIdle(idle),
    .cpuSleep(sleep), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    req <= '{addr: a, wrData: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    v = rdData;
    if (what != "") chk(what, v & m, e);
  endtask : rchk
  task automatic edges(input int k);
    repeat (k) begin
      @(posedge clk);
      level <= ~level;
      stamp <= stamp + 16'h0001;
      repeat (5) @(posedge clk);
    end
    #1;
  endtask : edges
  function automatic logic [15:0] ctlw(input logic s, input logic [2:0] t, input logic [1:0] p, input logic [2:0] m);
    return {2'b00, s, t, 3'b000, p, 2'b00, m};
  endfunction : ctlw
  // Passing through mode off empties the buffer and restarts the counters.
  task automatic cfg(input logic [15:0] c);
    wr(OFS_CONTROL_ONE, 16'h0000);
    wr(OFS_CONTROL_ONE, c);
    wr(OFS_IRQ_CLEAR, 16'h0003);
  endtask : cfg
  task automatic tcase(input string what, input logic [15:0] c, input int k, input logic [15:0] e);
    cfg(c);
    edges(k);
    n = 0;
    rchk("", OFS_BUFFER, 16'h0000, 16'h0000);
    while (v !== 16'h0000 && n < 9) begin
      n++;
      rchk("", OFS_BUFFER, 16'h0000, 16'h0000);
    end
    chk(what, 16'(n), e);
  endtask : tcase
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_pinsel();
    logic [6:0] codes [4] = '{PIN_GROUND, PIN_COMPARATOR, PIN_LAST, 7'h25};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_INPUT_SELECT, {9'h1AB, codes[i]});
      pinSel <= codes[i];
      tcase("pin capture", ctlw(1'b0, TB_TIMER2, 2'b00, MODE_RISE), 2, 16'(i != 0));
      rchk("pin select", OFS_INPUT_SELECT, 16'hFFFF, {9'h0AA, codes[i]});
    end
  endtask : t_pinsel
  task automatic t_timebase();
    logic [2:0]  sels [5] = '{TB_TIMER2, TB_TIMER4, TB_TIMER5, TB_TIMER1, TB_RESERVED};
    logic [15:0] flip [4] = '{16'h0000, 16'h2000, 16'h3000, 16'h1000};
    for (int i = 0; i < 5; i++) begin
      cfg(ctlw(1'b0, sels[i], 2'b00, MODE_RISE));
      edges(2);
      rchk("not empty", OFS_CONTROL_ONE, 16'h0008, 16'h0008);
      rchk("timebase", OFS_BUFFER, 16'hFFFF, (i == 4) ? 16'h0000 : (stamp - 16'h0001) ^ flip[i]);
      rchk("empty", OFS_CONTROL_ONE, 16'h0008, 16'h0000);
    end
    cfg(ctlw(1'b0, TB_PERIPHERAL, 2'b00, MODE_RISE));
    edges(4);
    rchk("", OFS_BUFFER, 16'h0000, 16'h0000);
    rchk("periph step", OFS_BUFFER, 16'hFFFF, v + 16'h000C);
  endtask : t_timebase
  task automatic t_fifo();
    logic [15:0] b;
    cfg(ctlw(1'b0, TB_TIMER2, 2'b00, MODE_RISE));
    b = stamp;
    edges(10);
    rchk("flags full", OFS_CONTROL_ONE, 16'h0018, 16'h0018);
    wr(OFS_IRQ_STATUS, 16'h0000);
    wr(OFS_BUFFER, 16'hFFFF);
    wr(4'h9, 16'hFFFF);
    rchk("status", OFS_IRQ_STATUS, 16'hFFFF, 16'h0003);
    rchk("unmapped", 4'h9, 16'hFFFF, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      rchk("order", OFS_BUFFER, 16'hFFFF, b + 16'(2 * k + 1));
    end
    rchk("flags empty", OFS_CONTROL_ONE, 16'h0018, 16'h0000);
  endtask : t_fifo
  task automatic t_modes();
    logic [2:0]  m [9] = '{MODE_RISE4, MODE_RISE4, MODE_RISE16, MODE_EVERY, MODE_RISE, MODE_FALL,
                           MODE_UNUSED, MODE_OFF, MODE_WAKE};
    int          tg [9] = '{14, 16, 32, 4, 6, 6, 4, 4, 4};
    logic [15:0] c [9] = '{16'h0001, 16'h0002, 16'h0001, 16'h0004, 16'h0003, 16'h0003, 16'h0000,
                           16'h0000, 16'h0000};
    slow <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      tcase("mode count", ctlw(1'b0, TB_TIMER2, 2'b00, m[i]), tg[i], c[i]);
    end
    slow <= 1'b0;
  endtask : t_modes
  task automatic t_irq();
    logic [1:0] per [3] = '{2'b11, 2'b10, 2'b00};
    int         nth [3] = '{4, 3, 1};
    wr(OFS_IRQ_ENABLE, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      cfg(ctlw(1'b0, TB_TIMER2, per[i], MODE_RISE));
      for (int k = 1; k <= nth[i]; k++) begin
        edges(2);
        chk("irq count", 16'(irq), 16'(k == nth[i]));
      end
    end
    cfg(ctlw(1'b0, TB_TIMER2, 2'b11, MODE_EVERY));
    edges(1);
    chk("edge irq", 16'(irq), 16'h0001);
    wr(OFS_IRQ_ENABLE, 16'h0000);
    cfg(ctlw(1'b0, TB_TIMER2, 2'b00, MODE_EVERY));
    edges(1);
    chk("irq masked", 16'(irq), 16'h0000);
    wr(OFS_IRQ_ENABLE, 16'h0003);
    #1;
    chk("irq unmasked", 16'(irq), 16'h0001);
    wr(OFS_IRQ_CLEAR, 16'h0001);
    #1;
    chk("irq cleared", 16'(irq), 16'h0000);
  endtask : t_irq
  task automatic t_idle();
    logic       st [3] = '{1'b1, 1'b0, 1'b1};
    logic       id [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      idle <= id[i];
      tcase("idle stop", ctlw(st[i], TB_TIMER2, 2'b00, MODE_RISE), 2, 16'(!(st[i] && id[i])));
    end
    sleep <= 1'b1;
    cfg(ctlw(1'b0, TB_TIMER2, 2'b00, MODE_WAKE));
    edges(2);
    chk("wake irq", 16'(irq), 16'h0001);
    rchk("wake empty", OFS_CONTROL_ONE, 16'h0008, 16'h0000);
    sleep <= 1'b0;
    wr(OFS_IRQ_CLEAR, 16'h0003);
    edges(2);
    chk("awake irq", 16'(irq), 16'h0000);
  endtask : t_idle
  task automatic close_out();
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rchk("reset value", 4'(a), 16'hFFFF, 16'h0000);
    end
    t_pinsel();
    t_timebase();
    t_fifo();
    t_modes();
    t_irq();
    t_idle();
    close_out();
  end
endmodule : tb
